/* File: timer_core_pkg.sv */
// Purpose: shared constants and types of the three-timer core
// Assumes: 8-bit register bus, one system clock
// Notes: all state types are packed so the core can register them as one word
package timer_core_pkg;

  localparam int NUM_TIMERS = 3;
  localparam int STD_IDX = 2;
  localparam int CNT_W = 10;
  localparam int ADDR_W = 5;
  localparam int EVT_W = 2 * NUM_TIMERS;

  // register offsets inside one timer slot (slot = address bits 4:3)
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_CMPA_LO = 3'h4;
  localparam logic [2:0] REG_CMPA_HI = 3'h5;
  localparam logic [ADDR_W-1:0] REG_INT_STATUS = 5'h18;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 5'h19;

  // event bit positions inside a timer's pair of status bits
  localparam int EVT_A_POS = 0;
  localparam int EVT_P_POS = 1;

  // prescaler terminal counts
  localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
  localparam logic [3:0] H_DIV16_LAST = 4'hf;
  localparam logic [5:0] H_DIV64_LAST = 6'h3f;

  typedef enum logic [2:0] {
    CLK_SYS_DIV4 = 3'h0,
    CLK_SYS = 3'h1,
    CLK_H_DIV16 = 3'h2,
    CLK_H_DIV64 = 3'h3,
    CLK_SUB = 3'h4,
    CLK_SUB_ALT = 3'h5,
    CLK_EXT_RISE = 3'h6,
    CLK_EXT_FALL = 3'h7
  } clk_sel_t;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_PULSE = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } op_mode_t;

  // compare mode: keep/low/high/toggle; pwm mode: inactive/active/waveform
  typedef enum logic [1:0] {
    PIN_KEEP = 2'h0,
    PIN_LOW = 2'h1,
    PIN_HIGH = 2'h2,
    PIN_TOGGLE = 2'h3
  } pin_act_t;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b01,
    PULSE_RUN = 2'b10
  } pulse_state_t;

  typedef struct packed {
    logic pause;
    clk_sel_t clk_sel;
    logic on;
    logic [2:0] period_sel;
  } ctrl0_t;

  typedef struct packed {
    op_mode_t mode;
    pin_act_t pin_act;
    logic out_init;
    logic polarity;
    logic duty_swap;
    logic clr_on_a;
  } ctrl1_t;

  typedef struct packed {
    ctrl0_t c0;
    ctrl1_t c1;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] cmp_a;
    logic [7:0] shadow;
    logic level;
    logic pin;
    logic on_prev;
    pulse_state_t pulse;
  } timer_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } pin_sync_t;

  typedef struct packed {
    timer_t [NUM_TIMERS-1:0] tmr;
    pin_sync_t [NUM_TIMERS-1:0] ext;
    pin_sync_t high_clk;
    pin_sync_t sub_clk;
    logic [1:0] sys_div;
    logic [5:0] h_div;
    logic [EVT_W-1:0] int_status;
    logic [EVT_W-1:0] int_mask;
    logic irq;
    logic std_pin_n;
    logic [7:0] rdata;
  } core_state_t;

  localparam timer_t TIMER_RESET = '{
    c0: '0, c1: '0, count: '0, cmp_a: '0, shadow: '0,
    level: 1'b0, pin: 1'b0, on_prev: 1'b0, pulse: PULSE_IDLE};

endpackage

/* File: timer_trio.sv */
// Purpose: two compact timers and one standard timer behind one register port
// Assumes: high and subsidiary clocks arrive as levels and are sampled here
// Notes: each timer owns one byte shadow shared by counter and compare A
`timescale 1ns/10ps
module timer_trio
  import timer_core_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic high_internal_clock_i,
  input wire logic subsidiary_clock_i,
  input wire logic [1:0] timer_ext_clock_pin_i,
  input wire logic standard_timer_ext_clock_pin_i,
  output logic [1:0] compact_timer_out_pin_o,
  output logic standard_timer_out_pin_o,
  output logic standard_timer_out_pin_inverted_o,
  output logic irq_o
);

  core_state_t s_r;
  core_state_t s_nxt;

  function automatic logic pick_tick(input clk_sel_t sel, input logic d4, input logic h16,
                                     input logic h64, input logic sub, input logic rise,
                                     input logic fall);
    case (sel)
      CLK_SYS_DIV4: pick_tick = d4;
      CLK_SYS: pick_tick = 1'b1;
      CLK_H_DIV16: pick_tick = h16;
      CLK_H_DIV64: pick_tick = h64;
      CLK_SUB, CLK_SUB_ALT: pick_tick = sub;
      CLK_EXT_RISE: pick_tick = rise;
      CLK_EXT_FALL: pick_tick = fall;
      default: pick_tick = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] hi_byte(input logic [CNT_W-1:0] v);
    hi_byte = 8'(v >> 8);
  endfunction

  always_comb begin
    timer_t t;
    logic [NUM_TIMERS-1:0] ext_pin;
    logic [EVT_W-1:0] events;
    logic [EVT_W-1:0] w1c;
    logic h_edge;
    logic sub_edge;
    logic d4;
    logic h16;
    logic h64;
    logic rise;
    logic fall;
    logic tick;
    logic hit_a;
    logic hit_p;
    logic clr;
    logic period_hit;
    logic duty_hit;
    logic pulse_mode;
    logic [CNT_W-1:0] inc;
    t = TIMER_RESET;
    h_edge = 1'b0;
    sub_edge = 1'b0;
    d4 = 1'b0;
    h16 = 1'b0;
    h64 = 1'b0;
    ext_pin = {standard_timer_ext_clock_pin_i, timer_ext_clock_pin_i};
    events = '0;
    w1c = '0;
    tick = 1'b0;
    hit_a = 1'b0;
    hit_p = 1'b0;
    clr = 1'b0;
    period_hit = 1'b0;
    duty_hit = 1'b0;
    pulse_mode = 1'b0;
    inc = '0;
    rise = 1'b0;
    fall = 1'b0;
    s_nxt = s_r;
    s_nxt.rdata = '0;

    // pin and foreign-clock samplers; only the second and third stages feed logic
    for (int i = 0; i < NUM_TIMERS; i++) begin
      s_nxt.ext[i].meta = ext_pin[i];
      s_nxt.ext[i].sync = s_r.ext[i].meta;
      s_nxt.ext[i].prev = s_r.ext[i].sync;
    end
    s_nxt.high_clk.meta = high_internal_clock_i;
    s_nxt.high_clk.sync = s_r.high_clk.meta;
    s_nxt.high_clk.prev = s_r.high_clk.sync;
    s_nxt.sub_clk.meta = subsidiary_clock_i;
    s_nxt.sub_clk.sync = s_r.sub_clk.meta;
    s_nxt.sub_clk.prev = s_r.sub_clk.sync;

    // shared prescalers
    h_edge = s_r.high_clk.sync & ~s_r.high_clk.prev;
    sub_edge = s_r.sub_clk.sync & ~s_r.sub_clk.prev;
    d4 = (s_r.sys_div == SYS_DIV4_LAST);
    h16 = h_edge & (s_r.h_div[3:0] == H_DIV16_LAST);
    h64 = h_edge & (s_r.h_div == H_DIV64_LAST);
    s_nxt.sys_div = s_r.sys_div + 2'h1;
    if (h_edge) begin
      s_nxt.h_div = s_r.h_div + 6'h01;
    end

    for (int i = 0; i < NUM_TIMERS; i++) begin
      t = s_r.tmr[i];
      rise = s_r.ext[i].sync & ~s_r.ext[i].prev;
      fall = ~s_r.ext[i].sync & s_r.ext[i].prev;
      // compact timers treat the pulse code as undefined and leave the pin alone
      pulse_mode = (i == STD_IDX) && (t.c1.mode == MODE_PULSE);
      tick = pick_tick(t.c0.clk_sel, d4, h16, h64, sub_edge, rise, fall)
             & t.c0.on & ~t.c0.pause;
      if (pulse_mode && t.pulse != PULSE_RUN) begin
        tick = 1'b0;
      end
      t.on_prev = t.c0.on;
      if (t.c0.on && !s_r.tmr[i].on_prev) begin
        // a fresh start restarts the count and restores the pin
        t.count = '0;
        t.level = t.c1.out_init;
        t.pulse = PULSE_IDLE;
      end else begin
        if (pulse_mode && t.c0.on && t.pulse == PULSE_IDLE && rise) begin
          t.pulse = PULSE_RUN;
          t.count = '0;
          t.level = 1'b1;
        end
        if (tick) begin
          inc = CNT_W'(t.count + 1'b1);
          hit_a = (inc == t.cmp_a);
          if (t.c0.period_sel == 3'h0) begin
            hit_p = (t.count == '1);
          end else begin
            hit_p = (inc == {t.c0.period_sel, (CNT_W-3)'(0)});
          end
          events[2*i+EVT_A_POS] = hit_a;
          events[2*i+EVT_P_POS] = hit_p;
          clr = t.c1.clr_on_a ? hit_a : hit_p;
          period_hit = t.c1.duty_swap ? hit_a : hit_p;
          duty_hit = t.c1.duty_swap ? hit_p : hit_a;
          case (t.c1.mode)
            MODE_COMPARE: begin
              if (hit_a) begin
                case (t.c1.pin_act)
                  PIN_LOW: t.level = 1'b0;
                  PIN_HIGH: t.level = 1'b1;
                  PIN_TOGGLE: t.level = ~t.level;
                  default: t.level = t.level;
                endcase
              end
            end
            MODE_PWM: begin
              clr = period_hit;
              if (t.c1.pin_act == PIN_HIGH) begin
                if (clr) begin
                  t.level = 1'b1;
                end else if (duty_hit) begin
                  t.level = 1'b0;
                end
              end
            end
            MODE_PULSE: begin
              if (pulse_mode && hit_a) begin
                t.level = 1'b0;
                t.pulse = PULSE_IDLE;
              end
            end
            default: t.level = t.level;
          endcase
          t.count = clr ? '0 : inc;
        end
        // pwm forced levels hold regardless of counting
        if (t.c1.mode == MODE_PWM && t.c1.pin_act == PIN_KEEP) begin
          t.level = 1'b0;
        end
        if (t.c1.mode == MODE_PWM && t.c1.pin_act == PIN_LOW) begin
          t.level = 1'b1;
        end
      end

      // register port; the shadow makes multi-byte values coherent
      if (wr_i && addr_i[4:3] == 2'(i)) begin
        case (addr_i[2:0])
          REG_CTRL0: t.c0 = ctrl0_t'(wdata_i);
          REG_CTRL1: t.c1 = ctrl1_t'(wdata_i);
          REG_CMPA_LO: t.shadow = wdata_i;
          REG_CMPA_HI: t.cmp_a = CNT_W'({wdata_i, t.shadow});
          default: t.shadow = t.shadow;
        endcase
      end
      if (rd_i && addr_i[4:3] == 2'(i)) begin
        case (addr_i[2:0])
          REG_CTRL0: s_nxt.rdata = 8'(s_r.tmr[i].c0);
          REG_CTRL1: s_nxt.rdata = 8'(s_r.tmr[i].c1);
          REG_CNT_LO, REG_CMPA_LO: s_nxt.rdata = s_r.tmr[i].shadow;
          REG_CNT_HI: begin
            s_nxt.rdata = hi_byte(s_r.tmr[i].count);
            t.shadow = s_r.tmr[i].count[7:0];
          end
          REG_CMPA_HI: begin
            s_nxt.rdata = hi_byte(s_r.tmr[i].cmp_a);
            t.shadow = s_r.tmr[i].cmp_a[7:0];
          end
          default: s_nxt.rdata = '0;
        endcase
      end
      t.pin = t.level ^ t.c1.polarity;
      s_nxt.tmr[i] = t;
    end
    s_nxt.std_pin_n = ~s_nxt.tmr[STD_IDX].pin;

    // interrupt block; a new event beats a same-cycle clear
    if (wr_i && addr_i == REG_INT_STATUS) begin
      w1c = wdata_i[EVT_W-1:0];
    end
    if (wr_i && addr_i == REG_INT_MASK) begin
      s_nxt.int_mask = wdata_i[EVT_W-1:0];
    end
    if (rd_i && addr_i == REG_INT_STATUS) begin
      s_nxt.rdata = 8'(s_r.int_status);
    end
    if (rd_i && addr_i == REG_INT_MASK) begin
      s_nxt.rdata = 8'(s_r.int_mask);
    end
    s_nxt.int_status = (s_r.int_status & ~w1c) | events;
    s_nxt.irq = |(s_nxt.int_status & s_nxt.int_mask);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
      // inverted pin stays the complement of the cleared pin even in reset
      s_r.std_pin_n <= 1'b1;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        s_r.tmr[i] <= TIMER_RESET;
      end
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign compact_timer_out_pin_o = {s_r.tmr[1].pin, s_r.tmr[0].pin};
  assign standard_timer_out_pin_o = s_r.tmr[STD_IDX].pin;
  assign standard_timer_out_pin_inverted_o = s_r.std_pin_n;
  assign irq_o = s_r.irq;

endmodule

/* File: ext_source.sv */
// Purpose: far side of the timer trio: free clocks and pin pulses
// Assumes: steps taken on the system clock edge
// Notes: oscillators run free; pins idle low
`timescale 1ns/10ps
module ext_source (
  input wire logic sys_clk_i,
  output logic high_clk_o,
  output logic sub_clk_o,
  output logic [2:0] ext_o
);
  logic [3:0] div_r = 4'h0;
  initial ext_o = 3'h0;
  always @(posedge sys_clk_i) div_r <= div_r + 4'h1;
  assign high_clk_o = div_r[1];
  assign sub_clk_o = div_r[3];
  task automatic set(input int w, input logic v);
    @(posedge sys_clk_i);
    ext_o[w] <= v;
  endtask
  // five cycles per level so the sampler never misses one
  task automatic burst(input int w, input int n);
    repeat (n) begin
      set(w, 1'b1);
      repeat (4) @(posedge sys_clk_i);
      set(w, 1'b0);
      repeat (4) @(posedge sys_clk_i);
    end
  endtask
endmodule

/* File: timer_trio_props.sv */
// Purpose: port checks of the timer trio
// Assumes: ce_i stays high
// Notes: compare A byte pair checks watch timer 0 only; the high byte width check covers every timer
`timescale 1ns/10ps
module timer_trio_props
  import timer_core_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic high_internal_clock_i,
  input wire logic subsidiary_clock_i,
  input wire logic [1:0] timer_ext_clock_pin_i,
  input wire logic standard_timer_ext_clock_pin_i,
  input wire logic [1:0] compact_timer_out_pin_o,
  input wire logic standard_timer_out_pin_o,
  input wire logic standard_timer_out_pin_inverted_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_inv_pair: assert property ($past(reset_n_i) |-> standard_timer_out_pin_inverted_o == !standard_timer_out_pin_o)
    else $error("inverted pin wrong");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside answer");
  a_unmapped_zero: assert property (rd_i && (addr_i > REG_INT_MASK || (addr_i < REG_INT_STATUS && addr_i[2:1] == 2'h3))
    |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_high_width: assert property (rd_i && addr_i < REG_INT_STATUS && (addr_i[2:0] == REG_CNT_HI
    || addr_i[2:0] == REG_CMPA_HI) |=> rdata_o[7:2] == 6'h00)
    else $error("high byte too wide");
  a_ctrl_back: assert property (wr_i && addr_i < REG_INT_STATUS && addr_i[2:1] == 2'h0 ##1 rd_i && $stable(addr_i)
    |=> rdata_o == $past(wdata_i, 2))
    else $error("control readback wrong");
  a_cmpa_high: assert property (wr_i && addr_i == 5'h05 ##1 rd_i && addr_i == 5'h05
    |=> rdata_o == ($past(wdata_i, 2) & 8'h03))
    else $error("compare high readback wrong");
  a_cmpa_pair: assert property (wr_i && addr_i == 5'h04 ##1 wr_i && addr_i == 5'h05 ##1 rd_i && addr_i == 5'h05
    ##1 rd_i && addr_i == 5'h04 |=> rdata_o == $past(wdata_i, 4))
    else $error("compare low pair wrong");
  a_mask_quiet: assert property (wr_i && addr_i == REG_INT_MASK && wdata_i[5:0] == 6'h00
    ##1 !(wr_i && addr_i == REG_INT_MASK) |=> !irq_o)
    else $error("irq with mask clear");
  c_irq: cover property ($rose(irq_o));
  c_pulse: cover property ($fell(standard_timer_out_pin_o));
  c_toggle: cover property ($changed(compact_timer_out_pin_o[0]));
endmodule
bind timer_trio timer_trio_props i_timer_trio_props (.sys_clk_i, .reset_n_i, .ce_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .high_internal_clock_i, .subsidiary_clock_i, .timer_ext_clock_pin_i,
  .standard_timer_ext_clock_pin_i, .compact_timer_out_pin_o, .standard_timer_out_pin_o,
  .standard_timer_out_pin_inverted_o, .irq_o);

/* File: tb_timer_trio.sv */
// Purpose: self-checking bench of the timer trio
// Assumes: ce_i held high except for one write in t_pwm; each bus op is one cycle
// Notes: counts from free clocks get a small margin
`timescale 1ns/10ps
module tb_timer_trio
  import timer_core_pkg::*;
  ;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ce_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic [7:0] rdata_o, q;
  logic [1:0] cpin;
  logic spin, spin_n, irq, hclk, sclk;
  logic [2:0] ext;
  logic [9:0] v;
  int bad_count = 0;
  int check_count = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  timer_trio i_timer_trio (.sys_clk_i, .reset_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .high_internal_clock_i(hclk), .subsidiary_clock_i(sclk), .timer_ext_clock_pin_i(ext[1:0]),
    .standard_timer_ext_clock_pin_i(ext[2]), .compact_timer_out_pin_o(cpin), .standard_timer_out_pin_o(spin),
    .standard_timer_out_pin_inverted_o(spin_n), .irq_o(irq));
  ext_source i_ext_source (.sys_clk_i, .high_clk_o(hclk), .sub_clk_o(sclk), .ext_o(ext));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    #1 q = rdata_o;
  endtask
  task automatic tick(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic rd16(input logic [4:0] b);
    op(0, b + 5'h3, 8'h0);
    v[9:8] = q[1:0];
    op(0, b + 5'h2, 8'h0);
    v[7:0] = q;
  endtask
  task automatic t_regs();
    for (int t = 0; t < 3; t++) begin
      op(1, 5'(t * 8), 8'h72);
      op(0, 5'(t * 8), 8'h0);
      check(q, 8'h72);
      op(1, 5'(t * 8 + 1), 8'h3d);
      op(0, 5'(t * 8 + 1), 8'h0);
      check(q, 8'h3d);
    end
    op(0, 5'h1f, 8'h0);
    check(q, 8'h00);
    op(0, 5'h0e, 8'h0);
    check(q, 8'h00);
    tick(1);
    $display("t_regs done");
  endtask
  task automatic t_pair();
    op(1, 5'h04, 8'ha5);
    op(1, 5'h05, 8'h02);
    op(0, 5'h05, 8'h0);
    check(q, 8'h02);
    op(0, 5'h04, 8'h0);
    check(q, 8'ha5);
    op(1, 5'h04, 8'h3c);
    op(0, 5'h05, 8'h0);
    op(0, 5'h04, 8'h0);
    check(q, 8'ha5);
    tick(1);
    $display("t_pair done");
  endtask
  task automatic t_cmp();
    logic p;
    op(1, 5'h04, 8'h03);
    op(1, 5'h05, 8'h00);
    op(1, 5'h01, 8'h31);
    op(1, 5'h00, 8'h18);
    tick(20);
    p = cpin[0];
    // cleared at the match, so the pin flips every third tick
    tick(3);
    check(cpin[0], !p);
    check(irq, 1'b0);
    op(1, 5'h01, 8'h11);
    tick(8);
    check(cpin[0], 1'b0);
    op(1, 5'h01, 8'h21);
    tick(8);
    check(cpin[0], 1'b1);
    op(0, REG_INT_STATUS, 8'h0);
    check(q[0], 1'b1);
    op(1, REG_INT_MASK, 8'h01);
    tick(2);
    check(irq, 1'b1);
    op(1, 5'h00, 8'h00);
    op(1, REG_INT_STATUS, 8'h3f);
    tick(2);
    check(irq, 1'b0);
    op(0, REG_INT_STATUS, 8'h0);
    check(q, 8'h00);
    op(1, REG_INT_MASK, 8'h00);
    tick(2);
    $display("t_cmp done");
  endtask
  task automatic t_pre();
    int div[5] = '{4, 1, 64, 256, 16};
    int e;
    op(1, 5'h09, 8'h00);
    for (int s = 0; s < 5; s++) begin
      op(1, 5'h08, {1'b0, 3'(s), 4'h8});
      tick(400);
      op(1, 5'h08, {1'b1, 3'(s), 4'h8});
      rd16(5'h08);
      e = 400 / div[s];
      check(v + 10'd2 >= e && v <= e + 2, 1'b1);
      op(1, 5'h08, 8'h00);
    end
    tick(1);
    $display("t_pre done");
  endtask
  task automatic t_ext();
    op(1, 5'h11, 8'h00);
    op(1, 5'h10, 8'h68);
    tick(1);
    i_ext_source.burst(2, 5);
    tick(6);
    rd16(5'h10);
    check(v, 10'd5);
    op(1, 5'h01, 8'h00);
    op(1, 5'h00, 8'h78);
    tick(1);
    i_ext_source.burst(0, 3);
    tick(6);
    rd16(5'h00);
    check(v, 10'd3);
    op(1, 5'h00, 8'h00);
    op(1, 5'h10, 8'h00);
    tick(1);
    $display("t_ext done");
  endtask
  task automatic t_pulse();
    int n = 0;
    op(1, 5'h14, 8'h05);
    op(1, 5'h15, 8'h00);
    op(1, 5'h11, 8'h40);
    op(1, 5'h10, 8'h18);
    tick(4);
    check(spin, 1'b0);
    i_ext_source.set(2, 1'b1);
    for (int i = 0; i < 20; i++) begin
      tick(1);
      n += spin;
      check(spin_n, !spin);
    end
    check(n >= 4 && n <= 6, 1'b1);
    i_ext_source.set(2, 1'b0);
    op(1, 5'h10, 8'h00);
    tick(1);
    $display("t_pulse done");
  endtask
  task automatic t_pwm();
    int n = 0;
    int m = 0;
    op(1, 5'h0c, 8'h20);
    op(1, 5'h0d, 8'h00);
    op(1, 5'h09, 8'ha0);
    op(1, 5'h08, 8'h19);
    tick(200);
    // one whole 128-tick period: high from period clear to duty match
    for (int i = 0; i < 128; i++) begin
      tick(1);
      n += cpin[1];
    end
    check(n, 10'd32);
    op(1, 5'h09, 8'ha4);
    tick(2);
    for (int i = 0; i < 128; i++) begin
      tick(1);
      m += cpin[1];
    end
    check(m, 10'd96);
    op(0, REG_INT_STATUS, 8'h0);
    check(q[3:2], 2'h3);
    op(1, 5'h08, 8'h00);
    op(1, REG_INT_STATUS, 8'h3f);
    // a write while the enable is low must not land
    ce_i <= 1'b0;
    op(1, REG_INT_MASK, 8'h3f);
    ce_i <= 1'b1;
    op(0, REG_INT_MASK, 8'h0);
    check(q, 8'h00);
    tick(1);
    $display("t_pwm done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    #1;
    t_regs();
    t_pair();
    t_cmp();
    t_pre();
    t_ext();
    t_pulse();
    t_pwm();
    wrap_up();
  end
  initial begin
    #40us;
    bad_count++;
    wrap_up();
  end
endmodule
